// ---- rtl/fena_msg_mem.sv ----
`timescale 1ns/100ps
module fena_msg_mem (
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       we,      // Byte write strobe
  input  wire logic [2:0] waddr,   // Write byte index
  input  wire logic [7:0] wdata,   // Write byte
  input  wire logic       re,      // Read strobe
  input  wire logic [2:0] raddr,   // Read byte index
  output logic      [7:0] rdata    // Registered read byte
);
  logic [7:0] mem_r [8];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem_r[raddr];
    end
  end
endmodule

// ---- rtl/fena_pkg.sv ----
// Operation
// - Inverter error or warning queues emergency message
// - No emergency message for link faults
// - Flags entry 10F3:05 enables sending, default 1
// - Message is eight bytes: code, error register, reserved
// - Code 5300 for inverter connection failure
// - Code 6341 for invalid PDO mapping
// - Code 6331 for corrupted nonvolatile data
// - Worn store: operate, stop saving history
// - Code FF00 for inverter warning
// - Code FF01 for inverter trip
// - Detected errors reported in error status entry
// - Switch value 00 selects software address mode
// - Software mode: stored address into alias register
// - Switch mode: switch value into alias register
// - Serial number readable at 1018:04
// - Info store check raises verification error
// - Mailbox delivery only pre-operational or above
package fena_pkg;
  localparam logic [15:0] REG_STATION    = 16'h0010;
  localparam logic [15:0] REG_ALIAS      = 16'h0012;
  localparam logic [15:0] OBJ_ERR_REG    = 16'h1001;
  localparam logic [15:0] OBJ_IDENT      = 16'h1018;
  localparam logic [7:0]  SUB_SERIAL     = 8'h04;
  localparam logic [15:0] OBJ_DIAG       = 16'h10F3;
  localparam logic [7:0]  SUB_FLAGS      = 8'h05;
  localparam logic [15:0] OBJ_ERR_STAT   = 16'h2002;
  localparam logic [7:0]  SUB_ERR_STAT   = 8'h01;
  localparam logic [15:0] OBJ_TXPDO_DIAG = 16'h1BFF;
  localparam logic [7:0]  SUB_MAP1       = 8'h01;
  localparam logic [7:0]  MAP_BITLEN     = 8'h08;
  localparam logic [15:0] OBJ_PDO_DETAIL = 16'h5200;
  localparam logic [15:0] OBJ_COMMAND    = 16'h5000;
  localparam logic [15:0] OBJ_CONTROL    = 16'h6040;
  localparam logic [7:0]  SUB_ZERO       = 8'h00;
  localparam int          FAULT_CLR_BIT  = 7;
  localparam logic        FLAGS_RST      = 1'b1;
  localparam logic [7:0]  ADDR_SW_SOFT   = 8'h00;
  localparam logic [15:0] ADDR_RST       = 16'h0000;
  localparam logic [15:0] EC_LINK        = 16'h5300;
  localparam logic [15:0] EC_PDO         = 16'h6341;
  localparam logic [15:0] EC_NVM         = 16'h6331;
  localparam logic [15:0] EC_WARN        = 16'hFF00;
  localparam logic [15:0] EC_TRIP        = 16'hFF01;
  localparam logic [2:0]  BYTE_CODE_LO   = 3'h0;
  localparam logic [2:0]  BYTE_CODE_HI   = 3'h1;
  localparam logic [2:0]  BYTE_ERR_REG   = 3'h2;
  localparam logic [2:0]  MSG_LAST       = 3'h7;
  localparam logic [7:0]  RSVD_BYTE      = 8'h00;
  localparam logic [7:0]  ERR_GENERIC    = 8'h01;
  // Link-layer state codes
  localparam logic [3:0]  AL_PREOP       = 4'h2;
  localparam logic [3:0]  AL_SAFEOP      = 4'h4;
  localparam logic [3:0]  AL_OP          = 4'h8;
  localparam int          NUM_EV         = 5;
  localparam logic [2:0]  EV_LINK        = 3'h0;
  localparam logic [2:0]  EV_PDO         = 3'h1;
  localparam logic [2:0]  EV_NVM         = 3'h2;
  localparam logic [2:0]  EV_WARN        = 3'h3;
  localparam logic [2:0]  EV_TRIP        = 3'h4;
  localparam logic [2:0]  SETTLE_CYC     = 3'h4;

  typedef struct packed {
    logic        obj;
    logic        wr;
    logic        rd;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } fena_acc_t;

  typedef struct packed {
    logic        vld;
    logic        err;
    logic [31:0] rdata;
  } fena_rsp_t;

  typedef struct packed {
    logic       vld;
    logic       last;
    logic [7:0] data;
  } fena_emcy_t;
endpackage

// ---- rtl/fena_top.sv ----
`timescale 1ns/100ps
module fena_top (
  input  wire logic                ref_clk,        // 20 MHz system clock
  input  wire logic                rst_n,          // Power-on reset, active low
  input  wire fena_pkg::fena_acc_t acc,            // Master access request
  output fena_pkg::fena_rsp_t      rsp,            // Access answer
  input  wire logic [3:0]          al_state,       // Link-layer state
  input  wire logic                inv_warn,       // Inverter warning pin
  input  wire logic                inv_trip,       // Inverter trip pin
  input  wire logic                inv_link_ok,    // Inverter connection good pin
  input  wire logic [7:0]          addr_sw,        // Node address switches
  input  wire logic                comm_err,       // Fieldbus link fault
  input  wire logic                pdo_map_err,    // PDO mapping invalid
  input  wire logic [15:0]         pdo_detail,     // PDO error detail
  input  wire logic                nvm_crc_err,    // Stored data corrupt
  input  wire logic                nvm_worn,       // Store end of life
  input  wire logic                info_valid,     // Info store contents ready
  input  wire logic                info_ok,        // Info store check passed
  input  wire logic [15:0]         info_node_addr, // Stored node address
  input  wire logic [31:0]         serial_no,      // Stored serial number
  input  wire logic                mbx_rdy,        // Mailbox takes byte
  output fena_pkg::fena_emcy_t     emcy,           // Emergency byte stream
  output logic                     fault_clr,      // Fault clear pulse
  output logic                     hist_save_en,   // History saving allowed
  output logic                     info_verify_err, // Info store error flag
  output logic [15:0]              node_addr       // Station node address
);
  import fena_pkg::*;

  typedef enum logic [1:0] {P_SETTLE, P_WAIT, P_RUN} fena_pwr_t;
  typedef enum logic [2:0] {S_IDLE, S_FILL, S_RD, S_LD, S_OUT} fena_snd_t;

  function automatic logic obj_hit(input fena_acc_t a, input logic [15:0] i,
                                   input logic [7:0] s);
    return a.obj && (a.idx == i) && (a.sub == s);
  endfunction

  function automatic logic [2:0] first_one(input logic [NUM_EV-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = NUM_EV - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] code_of(input logic [2:0] ev);
    logic [15:0] c;
    case (ev)
      EV_LINK: c = EC_LINK;
      EV_PDO:  c = EC_PDO;
      EV_NVM:  c = EC_NVM;
      EV_WARN: c = EC_WARN;
      default: c = EC_TRIP;
    endcase
    return c;
  endfunction

  function automatic logic [7:0] msg_byte(input logic [15:0] c, input logic [7:0] e,
                                          input logic [2:0] i);
    logic [7:0] b;
    if (i == BYTE_CODE_LO) begin
      b = c[7:0];
    end else if (i == BYTE_CODE_HI) begin
      b = c[15:8];
    end else if (i == BYTE_ERR_REG) begin
      b = e;
    end else begin
      b = RSVD_BYTE;
    end
    return b;
  endfunction

  // Pin synchronisers
  logic [10:0] pin_raw;
  logic [10:0] s1_r;
  logic [10:0] s2_r;
  logic [10:0] s3_r;
  logic [10:0] pin_r;
  logic [10:0] pin_nxt;
  logic        warn_s;
  logic        trip_s;
  logic        link_ok_s;
  logic [7:0]  sw_s;

  assign pin_raw   = {addr_sw, inv_link_ok, inv_trip, inv_warn};
  assign pin_nxt   = (s3_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
  assign warn_s    = pin_r[0];
  assign trip_s    = pin_r[1];
  assign link_ok_s = pin_r[2];
  assign sw_s      = pin_r[10:3];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r  <= pin_raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  // Power-on address load
  fena_pwr_t   pwr_r;
  fena_pwr_t   pwr_nxt;
  logic [2:0]  cnt_r;
  logic        load_now;
  logic        sw_soft;
  logic        run;
  logic [15:0] alias_r;
  logic [15:0] station_r;
  logic        info_err_r;

  assign load_now = (pwr_r == P_WAIT) && info_valid;
  assign sw_soft  = (sw_s == ADDR_SW_SOFT);
  assign run      = (pwr_r == P_RUN);

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      P_SETTLE: if (cnt_r == SETTLE_CYC) pwr_nxt = P_WAIT;
      P_WAIT:   if (info_valid) pwr_nxt = P_RUN;
      default:  pwr_nxt = P_RUN;
    endcase
  end

  // Access decode
  logic        hit_station;
  logic        hit_alias;
  logic        hit_flags;
  logic        hit_errreg;
  logic        hit_serial;
  logic        hit_stat;
  logic        hit_map;
  logic        hit_detail;
  logic        hit_cmd;
  logic        rd_ok;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        flag_r;
  logic [7:0]  err_reg;
  logic [7:0]  err_stat_r;
  fena_rsp_t   rsp_r;
  fena_rsp_t   rsp_nxt;
  logic        fault_clr_r;
  logic        hist_r;

  assign hit_station = !acc.obj && (acc.idx == REG_STATION);
  assign hit_alias   = !acc.obj && (acc.idx == REG_ALIAS);
  assign hit_flags   = obj_hit(acc, OBJ_DIAG, SUB_FLAGS);
  assign hit_errreg  = obj_hit(acc, OBJ_ERR_REG, SUB_ZERO);
  assign hit_serial  = obj_hit(acc, OBJ_IDENT, SUB_SERIAL);
  assign hit_stat    = obj_hit(acc, OBJ_ERR_STAT, SUB_ERR_STAT);
  assign hit_map     = obj_hit(acc, OBJ_TXPDO_DIAG, SUB_MAP1);
  assign hit_detail  = obj_hit(acc, OBJ_PDO_DETAIL, SUB_ZERO);
  assign hit_cmd     = obj_hit(acc, OBJ_COMMAND, SUB_ZERO)
                    || obj_hit(acc, OBJ_CONTROL, SUB_ZERO);

  assign rd_data = hit_station ? 32'(station_r)
                 : hit_alias   ? 32'(alias_r)
                 : hit_flags   ? 32'(flag_r)
                 : hit_errreg  ? 32'(err_reg)
                 : hit_serial  ? serial_no
                 : hit_stat    ? 32'(err_stat_r)
                 : hit_map     ? {OBJ_ERR_STAT, SUB_ERR_STAT, MAP_BITLEN}
                 : hit_detail  ? 32'(pdo_detail)
                 : 32'h0000_0000;
  assign rd_ok = hit_station | hit_alias | hit_flags | hit_errreg | hit_serial
               | hit_stat | hit_map | hit_detail;
  assign wr_ok = hit_station | hit_alias | hit_flags | hit_cmd;

  always_comb begin
    rsp_nxt.vld   = acc.rd | acc.wr;
    rsp_nxt.err   = (acc.rd & !rd_ok) | (acc.wr & !wr_ok);
    rsp_nxt.rdata = (acc.rd && rd_ok) ? rd_data : 32'h0000_0000;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r     <= P_SETTLE;
      cnt_r     <= 3'h0;
      alias_r   <= ADDR_RST;
      station_r <= ADDR_RST;
      info_err_r <= 1'b0;
      flag_r    <= FLAGS_RST;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r == P_SETTLE) cnt_r <= cnt_r + 3'h1;
      if (load_now) begin
        alias_r    <= sw_soft ? info_node_addr : 16'(sw_s);
        info_err_r <= info_err_r | !info_ok;
      end else if (acc.wr && hit_alias) begin
        alias_r <= acc.wdata[15:0];
      end
      if (acc.wr && hit_station) station_r <= acc.wdata[15:0];
      if (acc.wr && hit_flags) flag_r <= acc.wdata[0];
    end
  end

  // Event detection
  logic [NUM_EV-1:0] ev_cond;
  logic [NUM_EV-1:0] ev_prev_r;
  logic [NUM_EV-1:0] ev_rise;
  logic [NUM_EV-1:0] pend_r;
  logic [NUM_EV-1:0] pend_nxt;
  logic [NUM_EV-1:0] take_mask;
  logic [2:0]        pick;
  logic              mbx_open;
  logic              take;

  // Link fault kept out of the event set
  assign ev_cond  = {trip_s, warn_s, nvm_crc_err | nvm_worn, pdo_map_err, !link_ok_s};
  assign ev_rise  = ev_cond & ~ev_prev_r & {NUM_EV{run}};
  assign err_reg  = (|ev_cond) ? ERR_GENERIC : 8'h00;
  assign mbx_open = (al_state == AL_PREOP) || (al_state == AL_SAFEOP)
                 || (al_state == AL_OP);
  assign pick     = first_one(pend_r);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_r   <= '0;
      pend_r      <= '0;
      err_stat_r  <= 8'h00;
      rsp_r       <= '0;
      fault_clr_r <= 1'b0;
      hist_r      <= 1'b0;
    end else begin
      if (run) ev_prev_r <= ev_cond;
      pend_r      <= pend_nxt;
      err_stat_r  <= {2'h0, comm_err, ev_cond};
      rsp_r       <= rsp_nxt;
      fault_clr_r <= acc.wr && hit_cmd && acc.wdata[FAULT_CLR_BIT];
      hist_r      <= !nvm_worn;
    end
  end

  // Message sender
  fena_snd_t  snd_r;
  fena_snd_t  snd_nxt;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [15:0] code_r;
  logic [7:0] errb_r;
  logic       mem_we;
  logic       mem_re;
  logic [7:0] mem_rdata;
  fena_emcy_t emcy_r;
  fena_emcy_t emcy_nxt;

  assign take      = (snd_r == S_IDLE) && (|pend_r) && mbx_open && flag_r;
  assign take_mask = take ? (NUM_EV'(1) << pick) : '0;
  // New events win over the take clear
  assign pend_nxt  = flag_r ? ((pend_r & ~take_mask) | ev_rise) : '0;
  assign mem_we    = (snd_r == S_FILL);
  assign mem_re    = (snd_r == S_RD);

  always_comb begin
    snd_nxt  = snd_r;
    idx_nxt  = idx_r;
    emcy_nxt = emcy_r;
    case (snd_r)
      S_IDLE: begin
        idx_nxt = 3'h0;
        if (take) snd_nxt = S_FILL;
      end
      S_FILL: begin
        idx_nxt = idx_r + 3'h1;
        if (idx_r == MSG_LAST) snd_nxt = S_RD;
      end
      S_RD: snd_nxt = S_LD;
      S_LD: begin
        emcy_nxt.vld  = 1'b1;
        emcy_nxt.last = (idx_r == MSG_LAST);
        emcy_nxt.data = mem_rdata;
        snd_nxt       = S_OUT;
      end
      default: begin
        // A byte taken at this edge counts even as the mailbox closes
        if (mbx_rdy) begin
          emcy_nxt.vld = 1'b0;
          idx_nxt      = idx_r + 3'h1;
          snd_nxt      = (idx_r == MSG_LAST) ? S_IDLE : S_RD;
        end else if (!mbx_open) begin
          emcy_nxt.vld = 1'b0;
          snd_nxt      = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snd_r  <= S_IDLE;
      idx_r  <= 3'h0;
      code_r <= 16'h0000;
      errb_r <= 8'h00;
      emcy_r <= '0;
    end else begin
      snd_r  <= snd_nxt;
      idx_r  <= idx_nxt;
      emcy_r <= emcy_nxt;
      if (take) begin
        code_r <= code_of(pick);
        errb_r <= err_reg;
      end
    end
  end

  fena_msg_mem u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (mem_we),
    .waddr   (idx_r),
    .wdata   (msg_byte(code_r, errb_r, idx_r)),
    .re      (mem_re),
    .raddr   (idx_r),
    .rdata   (mem_rdata)
  );

  assign rsp            = rsp_r;
  assign emcy           = emcy_r;
  assign fault_clr      = fault_clr_r;
  assign hist_save_en   = hist_r;
  assign info_verify_err = info_err_r;
  assign node_addr      = station_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    take;
  endsequence
  sequence s_fill8;
    (snd_r == S_FILL) [*8] ##1 (snd_r == S_RD);
  endsequence

  a_take_gated: assert property (snd_r == S_IDLE && !(flag_r && mbx_open)
                                 |=> snd_r == S_IDLE)
    else $error("message taken while disabled or mailbox closed");
  a_fill_eight: assert property (s_take |=> s_fill8)
    else $error("message not filled with eight bytes");
  a_warn_code: assert property (take && pick == EV_WARN |=> code_r == EC_WARN)
    else $error("warning code wrong");
  a_trip_code: assert property (take && pick == EV_TRIP |=> code_r == EC_TRIP)
    else $error("trip code wrong");
  a_link_code: assert property (take && pick == EV_LINK |=> code_r == EC_LINK)
    else $error("connection code wrong");
  a_alias_soft: assert property (load_now && sw_soft |=> alias_r == $past(info_node_addr))
    else $error("stored address not loaded");
  a_alias_switch: assert property (load_now && !sw_soft |=> alias_r == 16'($past(sw_s)))
    else $error("switch address not loaded");
  a_flag_off: assert property (!flag_r |=> pend_r == '0)
    else $error("pending events kept while disabled");
  a_byte_hold: assert property (emcy_r.vld && !mbx_rdy && mbx_open |=>
                                emcy_r.vld && $stable(emcy_r.data))
    else $error("emergency byte dropped before taken");
  a_worn_hist: assert property (nvm_worn |=> !hist_save_en)
    else $error("history saving with worn store");
  a_info_check: assert property (load_now && !info_ok |=> info_verify_err [*2])
    else $error("info store error not raised");
  a_no_resend: assert property (run && $past(run) && ev_cond[EV_WARN] && $stable(ev_cond)
                                |-> !ev_rise[EV_WARN])
    else $error("repeat event on held condition");
endmodule

// ---- test/fena_master_model.sv ----
`timescale 1ns/100ps
module fena_master_model (
  input  wire logic                 ref_clk, // System clock
  input  wire logic                 rst_n,   // Reset, active low
  input  wire logic                 slow,    // Random stalls when high
  input  wire fena_pkg::fena_emcy_t emcy,    // Emergency byte stream
  output logic                      mbx_rdy, // Mailbox takes byte
  output logic [63:0]               msg,     // Last whole message, byte 0 lowest
  output logic [7:0]                msg_cnt, // Whole messages taken
  output logic [7:0]                len_err  // Messages not eight bytes long
);
  import fena_pkg::*;
  logic [2:0]  idx_r;
  logic [63:0] buf_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mbx_rdy <= 1'b0;
      idx_r   <= 3'h0;
      buf_r   <= 64'h0;
      msg     <= 64'h0;
      msg_cnt <= 8'h0;
      len_err <= 8'h0;
    end else begin
      mbx_rdy <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
      if (emcy.vld && mbx_rdy) begin
        buf_r[8*idx_r +: 8] <= emcy.data;
        idx_r <= idx_r + 3'h1;
        if (emcy.last) begin
          msg     <= {emcy.data, buf_r[55:0]};
          msg_cnt <= msg_cnt + 8'h1;
          idx_r   <= 3'h0;
          if (idx_r != 3'h7) begin
            len_err <= len_err + 8'h1;
          end
        end
      end
    end
  end
endmodule

// ---- test/fena_top_tb.sv ----
`timescale 1ns/100ps
module fena_top_tb;
  import fena_pkg::*;
  logic        ref_clk, rst_n, inv_warn, inv_trip, inv_link_ok, comm_err;
  logic        pdo_map_err, nvm_crc_err, nvm_worn, info_valid, info_ok, mbx_rdy;
  logic        fault_clr, hist_save_en, info_verify_err, slow;
  logic [3:0]  al_state;
  logic [7:0]  addr_sw, msg_cnt, len_err, msgs;
  logic [15:0] pdo_detail, info_node_addr, node_addr, alias_v;
  logic [31:0] serial_no;
  logic [63:0] msg;
  fena_acc_t   acc;
  fena_rsp_t   rsp;
  fena_emcy_t  emcy;
  int          failures, checked, cycles, clr_cnt, c0;

  fena_top fena_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .acc(acc), .rsp(rsp),
    .al_state(al_state), .inv_warn(inv_warn), .inv_trip(inv_trip),
    .inv_link_ok(inv_link_ok), .addr_sw(addr_sw), .comm_err(comm_err),
    .pdo_map_err(pdo_map_err), .pdo_detail(pdo_detail), .nvm_crc_err(nvm_crc_err),
    .nvm_worn(nvm_worn), .info_valid(info_valid), .info_ok(info_ok),
    .info_node_addr(info_node_addr), .serial_no(serial_no), .mbx_rdy(mbx_rdy),
    .emcy(emcy), .fault_clr(fault_clr), .hist_save_en(hist_save_en),
    .info_verify_err(info_verify_err), .node_addr(node_addr));

  fena_master_model fena_master_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .emcy(emcy), .mbx_rdy(mbx_rdy), .msg(msg), .msg_cnt(msg_cnt), .len_err(len_err));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (fault_clr === 1'b1) begin
      clr_cnt++;
    end
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // One request, answer checked just after the edge that takes the request
  task automatic xfer(input string name, input logic obj, input logic wr,
      input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
      input logic [31:0] exp_rd, input logic exp_err);
    @(posedge ref_clk);
    acc <= '{obj: obj, wr: wr, rd: !wr, idx: idx, sub: sub, wdata: wd};
    @(posedge ref_clk);
    acc.wr <= 1'b0;
    acc.rd <= 1'b0;
    #1;
    check({name, ".vld"}, 1, rsp.vld);
    check({name, ".err"}, exp_err, rsp.err);
    check({name, ".rdata"}, exp_rd, rsp.rdata);
  endtask

  task automatic power_on();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    msgs = 8'h0;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic set_cond(input int e, input logic v);
    @(posedge ref_clk);
    case (e)
      0: inv_link_ok <= !v;
      1: pdo_map_err <= v;
      2: nvm_crc_err <= v;
      3: inv_warn <= v;
      4: inv_trip <= v;
      5: comm_err <= v;
      default: nvm_worn <= v;
    endcase
  endtask

  function automatic logic [15:0] exp_code(input int e);
    case (e)
      0: return 16'h5300;
      1: return 16'h6341;
      2, 6: return 16'h6331;
      3: return 16'hFF00;
      default: return 16'hFF01;
    endcase
  endfunction

  function automatic logic [63:0] exp_msg(input logic [15:0] c);
    return {40'h0, 8'h01, c[15:8], c[7:0]};
  endfunction

  task automatic wait_msg(input logic [15:0] c);
    int n;
    msgs = msgs + 8'h1;
    n = 0;
    while (msg_cnt !== msgs && n < 600) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("msg_cnt", msgs, msg_cnt);
    check("msg", exp_msg(c), msg);
    check("len_err", 0, len_err);
  endtask

  task automatic no_msg();
    repeat (80) @(posedge ref_clk);
    check("msg_cnt idle", msgs, msg_cnt);
  endtask

  initial begin
    rst_n = 1'b0; acc = '0; al_state = AL_PREOP; slow = 1'b0;
    inv_warn = 1'b0; inv_trip = 1'b0; inv_link_ok = 1'b1; comm_err = 1'b0;
    pdo_map_err = 1'b0; nvm_crc_err = 1'b0; nvm_worn = 1'b0;
    info_valid = 1'b1; info_ok = 1'b1; info_node_addr = 16'h0;
    void'($urandom(32'h1597));
    addr_sw = 8'($urandom_range(1, 255));
    pdo_detail = 16'($urandom());
    serial_no = $urandom();
    power_on();
    check("node_addr reset", 0, node_addr);
    xfer("alias sw", 0, 0, 16'h0012, 0, 0, {24'h0, addr_sw}, 0);
    xfer("station wr", 0, 1, 16'h0010, 0, {24'h0, addr_sw}, 0, 0);
    xfer("station rd", 0, 0, 16'h0010, 0, 0, {24'h0, addr_sw}, 0);
    check("node_addr", {8'h0, addr_sw}, node_addr);
    check("verify ok", 0, info_verify_err);
    xfer("flags", 1, 0, 16'h10F3, 8'h05, 0, 1, 0);
    xfer("serial", 1, 0, 16'h1018, 8'h04, 0, serial_no, 0);
    xfer("pdo detail", 1, 0, 16'h5200, 8'h00, 0, {16'h0, pdo_detail}, 0);
    xfer("txpdo map", 1, 0, 16'h1BFF, 8'h01, 0, 32'h20020108, 0);
    xfer("err reg", 1, 0, 16'h1001, 8'h00, 0, 0, 0);
    xfer("ro write", 1, 1, 16'h1018, 8'h04, 32'h1, 0, 1);
    xfer("wo read", 1, 0, 16'h5000, 8'h00, 0, 0, 1);
    xfer("unmapped", 0, 0, 16'h0020, 0, 0, 0, 1);
    $display("test registers done");
    for (int e = 0; e < 7; e++) begin
      slow <= (e % 2 == 1);
      al_state <= (e < 4) ? AL_PREOP : AL_OP;
      set_cond(e, 1'b1);
      if (e == 5) begin
        no_msg();
      end else begin
        wait_msg(exp_code(e));
        no_msg();
      end
      if (e == 6) begin
        check("hist_save_en worn", 0, hist_save_en);
      end
      xfer("err stat", 1, 0, 16'h2002, 8'h01, 0, (e == 6) ? 32'h4 : 32'h1 << e, 0);
      xfer("err reg on", 1, 0, 16'h1001, 8'h00, 0, (e == 5) ? 32'h0 : 32'h1, 0);
      set_cond(e, 1'b0);
      no_msg();
    end
    check("hist_save_en", 1, hist_save_en);
    $display("test events done");
    al_state <= 4'h1;
    set_cond(3, 1'b1);
    no_msg();
    al_state <= AL_SAFEOP;
    wait_msg(16'hFF00);
    set_cond(3, 1'b0);
    $display("test mailbox state done");
    xfer("flags off", 1, 1, 16'h10F3, 8'h05, 0, 0, 0);
    xfer("flags rd", 1, 0, 16'h10F3, 8'h05, 0, 0, 0);
    set_cond(4, 1'b1);
    no_msg();
    set_cond(4, 1'b0);
    repeat (10) @(posedge ref_clk);
    xfer("flags on", 1, 1, 16'h10F3, 8'h05, 1, 0, 0);
    no_msg();
    $display("test flags done");
    for (int k = 0; k < 2; k++) begin
      c0 = clr_cnt;
      xfer("clr", 1, 1, k ? 16'h6040 : 16'h5000, 0, 32'h80, 0, 0);
      repeat (3) @(posedge ref_clk);
      check("fault_clr", c0 + 1, clr_cnt);
      xfer("no clr", 1, 1, k ? 16'h6040 : 16'h5000, 0, 32'h7F, 0, 0);
      repeat (3) @(posedge ref_clk);
      check("fault_clr idle", c0 + 1, clr_cnt);
    end
    $display("test fault clear done");
    addr_sw <= ADDR_SW_SOFT;
    info_node_addr <= 16'($urandom());
    info_ok <= 1'b0;
    power_on();
    alias_v = info_node_addr;
    xfer("alias soft", 0, 0, 16'h0012, 0, 0, {16'h0, alias_v}, 0);
    check("verify err", 1, info_verify_err);
    addr_sw <= 8'($urandom_range(1, 255));
    repeat (10) @(posedge ref_clk);
    xfer("alias held", 0, 0, 16'h0012, 0, 0, {16'h0, alias_v}, 0);
    $display("test software address done");
    stop_test();
  end
endmodule
